// ---- host_model.sv ----
// Host model: one write strobe per bench request.
// Idle strobes carry inverted bytes, never stale ones.
`timescale 1ns/10ps
module host_model (
  input wire logic clk_i, // Clock
  input wire logic req_i, // Request
  input wire logic [7:0] a_i, // Offset
  input wire logic [7:0] d_i, // Byte
  output limits_voltage_pkg::reg_wr_t wr_o // Strobe
);
  always @(posedge clk_i) begin
    wr_o <= req_i ? {1'b1, a_i, d_i} : {1'b0, ~a_i, ~d_i};
  end
endmodule : host_model

// ---- limits_regs_checker.sv ----
// Port checker for the limits and voltage registers.
// Sees only the block's ports; bound at the foot.
`timescale 1ns/10ps
module limits_regs_checker (
  input wire logic ref_clk_i, // Clock
  input wire logic nrst_i, // Reset
  input wire limits_voltage_pkg::reg_wr_t wr_i, // Write
  input wire logic [7:0] rd_addr_i, // Read addr
  input wire logic [7:0] rd_data_o, // Read data
  input wire logic select_gating_i, // Gating
  input wire logic thermal_shutdown_i, // Fault
  input wire logic short_circuit_fault_i, // Fault
  input wire logic [7:0] output_code_o, // Code
  input wire logic [1:0] prewarn_code_o, // Prewarn
  input wire logic [1:0] peak_code_o, // Peak
  input wire logic converter_on_o, // Run
  input wire logic powerup_start_o // Restart
);
  // ==========
  // Write decode and port properties
  wire lim_wr = wr_i.wr &&
    wr_i.addr == limits_voltage_pkg::LIMITS_CONFIGURATION_ADDR;
  wire hi_wr = wr_i.wr &&
    wr_i.addr == limits_voltage_pkg::OUTPUT_VOLTAGE_HIGH_SELECT_ADDR;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_spare_zero: assert property (
    $past(rd_addr_i) == 8'h16 |-> !rd_data_o[3]) else $error("spare");
  a_force_zero: assert property (
    $past(rd_addr_i) == 8'h16 |-> !rd_data_o[2]) else $error("force");
  a_fault_off: assert property (
    (thermal_shutdown_i || short_circuit_fault_i) [*4] |=> !converter_on_o)
    else $error("on in fault");
  a_prewarn_set: assert property (
    lim_wr && !wr_i.data[2] |-> ##2
    prewarn_code_o == $past(wr_i.data[5:4], 2)) else $error("prewarn");
  a_peak_set: assert property (
    lim_wr && !wr_i.data[2] |-> ##2
    peak_code_o == $past(wr_i.data[7:6], 2)) else $error("peak");
  a_force_clears: assert property (
    lim_wr && wr_i.data[2] ##1 !wr_i.wr |=>
    prewarn_code_o == 2'h0 && peak_code_o == 2'h0) else $error("defaults");
  a_high_code: assert property (
    hi_wr && !select_gating_i ##1 !wr_i.wr && !select_gating_i |=>
    output_code_o == ($past(wr_i.data, 2) > 8'hd8 ? 8'hd8 :
    $past(wr_i.data, 2))) else $error("high code");
  a_pulse_once: assert property (
    powerup_start_o |=> !powerup_start_o) else $error("restart");
endmodule : limits_regs_checker
bind regulator_limits_voltage_regs limits_regs_checker chk_u (.*);

// ---- limits_voltage_pkg.sv ----
// Constants and carrier types for the limits and output-voltage registers.
// Assumes a byte-wide register port driven by the serial control front end.
package limits_voltage_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] LIMITS_CONFIGURATION_ADDR = 8'h16;
  localparam logic [7:0] OUTPUT_VOLTAGE_HIGH_SELECT_ADDR = 8'h17;
  localparam logic [7:0] OUTPUT_VOLTAGE_LOW_SELECT_ADDR = 8'h18;

  // ==========================================================
  // Field positions in the limits register
  localparam int FAULT_ENABLE_A_BIT = 0;
  localparam int RESET_INDICATOR_BIT = 1;
  localparam int FORCE_RESET_BIT = 2;
  localparam int SPARE_BIT = 3;
  localparam int PREWARN_LSB = 4;
  localparam int PEAK_LSB = 6;

  // ==========================================================
  // Values after reset (plain defaults)
  localparam logic [7:0] LIMITS_RESET = 8'h02;
  localparam logic [7:0] HIGH_CODE_RESET = 8'h30;
  localparam logic [7:0] LOW_CODE_RESET = 8'h30;

  // ==========================================================
  // Output code range
  localparam logic [7:0] CODE_MAX = 8'hd8;
  localparam int VOUT_BASE_UV = 600000;
  localparam int VOUT_STEP_UV = 12500;

  typedef enum logic [1:0] {
    PREWARN_83C = 2'b00,
    PREWARN_94C = 2'b01,
    PREWARN_105C = 2'b10,
    PREWARN_116C = 2'b11
  } prewarn_t;

  typedef enum logic [1:0] {
    PEAK_5A2 = 2'b00,
    PEAK_5A8 = 2'b01,
    PEAK_6A2 = 2'b10,
    PEAK_6A8 = 2'b11
  } peak_t;

  typedef struct packed {
    peak_t peak_current_limit;
    prewarn_t thermal_prewarn_threshold;
    logic spare;
    logic force_register_reset;
    logic reset_indicator;
    logic fault_enable_a;
  } limits_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

endpackage : limits_voltage_pkg

// ---- regulator_limits_voltage_regs.sv ----
// Limits configuration and output voltage code registers of the regulator.
// Assumes the serial front end delivers one-cycle write strobes and a read
// address on ref_clk_i; fault and pin inputs are asynchronous levels.
// The converter, thermal comparator and current sense read the registered
// code outputs; none of them writes back into this block.
`timescale 1ns/10ps

// Functional notes
// - With re-arm cleared a thermal or short fault latches the converter off.
// - With re-arm set a fault ends in a new power-up keeping register values.
// - Every register reset loads the reset indicator with one.
// - Pre-warning codes 00 to 11 select 83, 94, 105 and 116 degrees C.
// - High-select code drives the output when select is high or gating off.
// - Output code zero is 0.6 V, each step adds 12.5 mV up to 3.3 V.
// - Codes from 0xd8 upward all saturate at the 3.3 V setting.
// - Low-select code drives the output when select is low and gating on.
module regulator_limits_voltage_regs (
  input wire logic ref_clk_i, // 40 MHz clock
  input wire logic nrst_i, // Synchronous reset, active low
  input wire limits_voltage_pkg::reg_wr_t wr_i, // Register write strobe
  input wire logic [7:0] rd_addr_i, // Register read address
  output logic [7:0] rd_data_o, // Read data
  input wire logic select_gating_i, // Select pin function enabled
  input wire logic voltage_select_pin_i, // Select pin, asynchronous
  input wire logic thermal_shutdown_i, // Thermal fault, asynchronous
  input wire logic short_circuit_fault_i, // Short fault, asynchronous
  output logic [7:0] output_code_o, // Active output voltage code
  output logic [1:0] prewarn_code_o, // Thermal pre-warning code
  output logic [1:0] peak_code_o, // Inductor peak limit code
  output logic converter_on_o, // Converter allowed to run
  output logic powerup_start_o // One-cycle fresh power-up request
);

  // ==========================================================
  // Input synchronisers
  // Bit 2 select pin, bit 1 thermal fault, bit 0 short fault
  wire [2:0] pins_async = {voltage_select_pin_i, thermal_shutdown_i,
                           short_circuit_fault_i};
  wire [2:0] pins_sync;

  // One two-stage synchroniser per pin; stage one feeds stage two only
  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic stage1_r;
    logic stage2_r;
    always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
        stage1_r <= 1'h0;
        stage2_r <= 1'h0;
      end else begin
        stage1_r <= pins_async[i];
        stage2_r <= stage1_r;
      end
    end
    assign pins_sync[i] = stage2_r;
  end

  wire sel_pin = pins_sync[2];
  // Both faults stop the converter alike; their sources are not kept
  wire fault = pins_sync[1] | pins_sync[0];

  // ==========================================================
  // Register file
  limits_voltage_pkg::limits_t limits_r;
  limits_voltage_pkg::limits_t limits_nxt;
  logic [7:0] high_code_r;
  logic [7:0] low_code_r;

  wire wr_limits = wr_i.wr &&
    (wr_i.addr == limits_voltage_pkg::LIMITS_CONFIGURATION_ADDR);
  wire wr_high = wr_i.wr &&
    (wr_i.addr == limits_voltage_pkg::OUTPUT_VOLTAGE_HIGH_SELECT_ADDR);
  wire wr_low = wr_i.wr &&
    (wr_i.addr == limits_voltage_pkg::OUTPUT_VOLTAGE_LOW_SELECT_ADDR);
  wire force_rst = wr_limits &&
    wr_i.data[limits_voltage_pkg::FORCE_RESET_BIT];
  wire regs_reset = !nrst_i || force_rst;

  always_comb begin
    limits_nxt = limits_voltage_pkg::limits_t'(wr_i.data);
    limits_nxt.spare = 1'b0;
    limits_nxt.force_register_reset = 1'b0;
  end

  // Default image shared by the register and output resets
  limits_voltage_pkg::limits_t limits_dflt;
  assign limits_dflt =
    limits_voltage_pkg::limits_t'(limits_voltage_pkg::LIMITS_RESET);

  // Faults never feed regs_reset, so settings survive a re-armed restart.
  // Limits register; the host clears the indicator with a plain write.
  always_ff @(posedge ref_clk_i) begin
    if (regs_reset) begin
      limits_r <= limits_dflt;
    end else if (wr_limits) begin
      limits_r <= limits_nxt;
    end
  end

  // code used with select high or gating off
  always_ff @(posedge ref_clk_i) begin
    if (regs_reset) begin
      high_code_r <= limits_voltage_pkg::HIGH_CODE_RESET;
    end else if (wr_high) begin
      high_code_r <= wr_i.data;
    end
  end

  // code used with select low and gating on
  always_ff @(posedge ref_clk_i) begin
    if (regs_reset) begin
      low_code_r <= limits_voltage_pkg::LOW_CODE_RESET;
    end else if (wr_low) begin
      low_code_r <= wr_i.data;
    end
  end

  // ==========================================================
  // Read mux; unmapped offsets read zero
  wire rd_hit_limits =
    rd_addr_i == limits_voltage_pkg::LIMITS_CONFIGURATION_ADDR;
  wire rd_hit_high =
    rd_addr_i == limits_voltage_pkg::OUTPUT_VOLTAGE_HIGH_SELECT_ADDR;
  wire rd_hit_low =
    rd_addr_i == limits_voltage_pkg::OUTPUT_VOLTAGE_LOW_SELECT_ADDR;
  // spare and force bits are stored as zero
  wire [7:0] rd_mux = rd_hit_limits ? limits_r :
                      rd_hit_high ? high_code_r :
                      rd_hit_low ? low_code_r : 8'h00;

  // ==========================================================
  // Voltage selection
  // high code when pin high or gating off
  // low code when pin low and gating on
  wire [7:0] sel_code = (!select_gating_i || sel_pin) ? high_code_r :
                        low_code_r;
  wire [7:0] clamp_code = (sel_code > limits_voltage_pkg::CODE_MAX) ?
                          limits_voltage_pkg::CODE_MAX : sel_code;

  // ==========================================================
  // Fault handling
  // Latch-off is left only through the reset pin; a forced register
  // reset restores settings but must not restart a latched converter
  typedef enum logic [1:0] {
    RUN_ST = 2'b00,
    FAULT_ST = 2'b01,
    LATCH_ST = 2'b10
  } fault_state_t;

  fault_state_t state_r;
  fault_state_t state_nxt;
  logic start_r;
  logic start_nxt;

  always_comb begin
    state_nxt = state_r;
    start_nxt = 1'h0;
    case (state_r)
      RUN_ST: begin
        if (fault && !limits_r.fault_enable_a) begin
          state_nxt = LATCH_ST;
        end else if (fault) begin
          state_nxt = FAULT_ST;
        end
      end
      FAULT_ST: begin
        if (fault && !limits_r.fault_enable_a) begin
          state_nxt = LATCH_ST;
        end else if (!fault) begin
          state_nxt = RUN_ST;
          start_nxt = limits_r.fault_enable_a;
        end
      end
      LATCH_ST: begin
        state_nxt = LATCH_ST;
      end
      default: begin
        // Unused code; fail safe by holding the converter off
        state_nxt = LATCH_ST;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_r <= RUN_ST;
      start_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      start_r <= start_nxt;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rd_data_o <= 8'h00;
      output_code_o <= limits_voltage_pkg::HIGH_CODE_RESET;
      prewarn_code_o <= limits_dflt.thermal_prewarn_threshold;
      peak_code_o <= limits_dflt.peak_current_limit;
      converter_on_o <= 1'h0;
    end else begin
      rd_data_o <= rd_mux;
      output_code_o <= clamp_code;
      prewarn_code_o <= limits_r.thermal_prewarn_threshold;
      // peak limit code to current sense
      peak_code_o <= limits_r.peak_current_limit;
      // Off while a fault stands or after latch-off
      converter_on_o <= !fault && (state_r != LATCH_ST);
    end
  end
  assign powerup_start_o = start_r;

endmodule : regulator_limits_voltage_regs

// ---- regulator_limits_voltage_regs_test.sv ----
// Bench: random and corner writes, read-back, select and fault paths.
// Assumes the host model adds one cycle to each write.
`timescale 1ns/10ps
module regulator_limits_voltage_regs_test;
  logic clk = 0, nrst = 0, req = 0, gate = 0, pin = 0, ts = 0, sc = 0;
  logic [7:0] a = 0, d = 0, ra = 0, rd, code;
  logic [1:0] pw, pk;
  logic on, pu;
  logic [31:0] lf = 79713;
  limits_voltage_pkg::reg_wr_t w;
  int mismatches = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  host_model host_u (.clk_i(clk), .req_i(req), .a_i(a), .d_i(d), .wr_o(w));
  regulator_limits_voltage_regs dut_u (.ref_clk_i(clk), .nrst_i(nrst),
    .wr_i(w), .rd_addr_i(ra), .rd_data_o(rd), .select_gating_i(gate),
    .voltage_select_pin_i(pin), .thermal_shutdown_i(ts),
    .short_circuit_fault_i(sc), .output_code_o(code), .prewarn_code_o(pw),
    .peak_code_o(pk), .converter_on_o(on), .powerup_start_o(pu));
  // ==========
  // Random source, expectations and bus tasks
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction : rnd
  function automatic logic [7:0] exp_code(logic [7:0] c);
    return (c > limits_voltage_pkg::CODE_MAX) ?
      limits_voltage_pkg::CODE_MAX : c;
  endfunction : exp_code
  function automatic logic [7:0] exp_limits(logic [7:0] v);
    logic [7:0] r;
    r = v;
    r[limits_voltage_pkg::SPARE_BIT] = 1'h0;
    r[limits_voltage_pkg::FORCE_RESET_BIT] = 1'h0;
    return r;
  endfunction : exp_limits
  task chk(logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  task wr(logic [7:0] ad, logic [7:0] dd);
    @(posedge clk) req <= 1;
    a <= ad;
    d <= dd;
    @(posedge clk) req <= 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : wr
  task rdc(logic [7:0] ad, logic [7:0] exp);
    @(posedge clk) ra <= ad;
    repeat (2) @(posedge clk);
    @(negedge clk) chk(rd, exp);
  endtask : rdc
  task conclude();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  initial begin
    logic [7:0] v;
    int n;
    repeat (6) @(posedge clk);
    nrst <= 1;
    rdc(8'h16, limits_voltage_pkg::LIMITS_RESET);
    wr(8'h16, 8'h00);
    for (int i = 0; i < 30; i++) begin
      v = (i < 3) ? 8'hd7 + 8'(i) : (i == 3 ? 8'hff : rnd());
      wr(8'h17, v);
      chk(code, exp_code(v));
      v = rnd() & 8'hfa;
      wr(8'h16, v);
      rdc(8'h16, exp_limits(v));
      chk({4'h0, pk, pw}, {4'h0, v[7:4]});
    end
    wr(8'h16, 8'h05);
    rdc(8'h16, limits_voltage_pkg::LIMITS_RESET);
    rdc(8'h17, limits_voltage_pkg::HIGH_CODE_RESET);
    wr(8'h18, 8'h11);
    wr(8'h17, 8'h22);
    @(posedge clk) gate <= 1;
    repeat (5) @(negedge clk);
    chk(code, 8'h11);
    @(posedge clk) pin <= 1;
    repeat (5) @(negedge clk);
    chk(code, 8'h22);
    chk(8'(on), 8'h01);
    wr(8'h16, 8'h01);
    @(posedge clk) ts <= 1;
    repeat (6) @(negedge clk);
    chk(8'(on), 8'h00);
    @(posedge clk) ts <= 0;
    n = 0;
    while (pu !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(8'(pu), 8'h01);
    rdc(8'h17, 8'h22);
    wr(8'h16, 8'h00);
    @(posedge clk) sc <= 1;
    repeat (6) @(negedge clk);
    @(posedge clk) sc <= 0;
    repeat (20) @(negedge clk);
    chk(8'(on), 8'h00);
    // Reset pin is the only way out of latch-off
    @(posedge clk) nrst <= 0;
    repeat (6) @(posedge clk);
    nrst <= 1;
    repeat (4) @(negedge clk);
    chk(8'(on), 8'h01);
    rdc(8'h16, limits_voltage_pkg::LIMITS_RESET);
    conclude();
  end
endmodule : regulator_limits_voltage_regs_test
